// ===== inc/bridge_regs_defines.svh
/*
 * Register offsets, reset values, field positions, encodings and timing
 * counts of the bridge configuration register bank.
 * Assumes a single core clock with a 20 ns period.
 */
`ifndef BRIDGE_REGS_DEFINES_SVH
`define BRIDGE_REGS_DEFINES_SVH

// ----------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------
`define REG_BAUD_LOW        8'h00
`define REG_BAUD_HIGH       8'h01
`define REG_PIN_CFG_LOW     8'h02
`define REG_PIN_CFG_HIGH    8'h03
`define REG_PIN_LEVEL       8'h04
`define REG_RESERVED        8'h05
`define REG_OWN_ADDR        8'h06
`define REG_SCL_LOW         8'h07
`define REG_SCL_HIGH        8'h08
`define REG_SCL_TIMEOUT     8'h09
`define REG_FRAME_STATUS    8'h0a

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define RST_BAUD_LOW        8'hf0
`define RST_BAUD_HIGH       8'h02
`define RST_PIN_CFG         8'h55
`define RST_PIN_LATCH       8'hff
`define RST_RESERVED        8'h00
`define RST_OWN_ADDR        8'h26
`define RST_SCL_LOW         8'h13
`define RST_SCL_HIGH        8'h13
`define RST_SCL_TIMEOUT     8'h66

// ----------------------------------------------------------------------
// Fields and codes
// ----------------------------------------------------------------------
`define TO_ENABLE_BIT       0
`define TO_VALUE_MSB        7
`define TO_VALUE_LSB        1
`define OWN_ADDR_MSB        7
`define OWN_ADDR_LSB        1
`define STAT_UPPER          4'hf
`define STAT_OK             4'h0
`define STAT_NO_ACK_ADDRESS 4'h1
`define STAT_NO_ACK_DATA    4'h2
`define STAT_TIMEOUT        4'h8
`define PIN_CFG_QUASI       2'h0
`define PIN_CFG_INPUT       2'h1
`define PIN_CFG_PUSH_PULL   2'h2
`define PIN_CFG_OPEN_DRAIN  2'h3
`define PIN_COUNT           8
`define BAUD_BASE           17'h00010

// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define CLK_PERIOD_NS       20
`define TO_UNIT_NS          4444444
`define TO_UNIT_CYCLES      (`TO_UNIT_NS / `CLK_PERIOD_NS)

`endif

// ===== inc/bridge_regs_pkg.sv
/*
 * Types shared by the bridge register bank and its pin bank.
 * Assumes the defines header supplies all numeric constants.
 */
package bridge_regs_pkg;

	typedef logic [1:0] pin_cfg_t;

	typedef enum logic [1:0] {
		PH_IDLE,
		PH_HIGH,
		PH_LOW
	} scl_phase_e;

endpackage

// ===== inc/pin_ctrl_if.sv
/*
 * Carrier between the register bank and the pin bank.
 * Assumes both ends run on the same clock.
 */
`timescale 1ns/100ps
`default_nettype none

interface pin_ctrl_if;
	bridge_regs_pkg::pin_cfg_t cfg [0:7];
	logic [7:0]                latch;
	logic [7:0]                level;

	modport ctrl
	(
		output cfg,
		output latch,
		input  level
	);

	modport bank
	(
		input  cfg,
		input  latch,
		output level
	);
endinterface

`default_nettype wire

// ===== rtl/pin_bank.sv
/*
 * Eight programmable I/O pin drivers and input synchronisers.
 * Assumes configuration and latch come from the register bank on the
 * same clock and that pad logic resolves drive, enable and pull-up.
 */
`include "bridge_regs_defines.svh"
`timescale 1ns/100ps
`default_nettype none

module pin_bank
(
	input  wire logic   CLK_I,
	input  wire logic   RST_N_I,
	pin_ctrl_if.bank    ctl,
	input  wire logic [7:0] GPIO_I,
	output logic      [7:0] GPIO_O,
	output logic      [7:0] GPIO_OE_N_O,
	output logic      [7:0] GPIO_WEAK_PU_O
);

	// ------------------------------------------------------------------
	// Input synchronisers
	// ------------------------------------------------------------------
	logic [7:0] sync_a;
	logic [7:0] sync_b;
	logic [7:0] sync_c;
	logic [7:0] level;

	always_ff @(posedge CLK_I or negedge RST_N_I)
	begin
		if (!RST_N_I)
		begin
			sync_a <= 8'h00;
			sync_b <= 8'h00;
			sync_c <= 8'h00;
		end
		else
		begin
			sync_a <= GPIO_I;
			sync_b <= sync_a;
			sync_c <= sync_b;
		end
	end

	always_ff @(posedge CLK_I or negedge RST_N_I)
	begin
		if (!RST_N_I)
			level <= 8'h00;
		else
			level <= (~(sync_b ^ sync_c) & sync_c) | ((sync_b ^ sync_c) & level);
	end

	assign ctl.level = level;

	// ------------------------------------------------------------------
	// Pin drivers
	// ------------------------------------------------------------------
	genvar p;
	generate
		for (p = 0; p < `PIN_COUNT; p++)
		begin : g_pin
			always_comb
			begin
				GPIO_O[p]         = 1'b0;
				GPIO_OE_N_O[p]    = 1'b1;
				GPIO_WEAK_PU_O[p] = 1'b0;
				unique case (ctl.cfg[p])
					`PIN_CFG_QUASI:
					begin
						GPIO_OE_N_O[p]    = ctl.latch[p];
						GPIO_WEAK_PU_O[p] = ctl.latch[p];
					end
					`PIN_CFG_INPUT:
					begin
						GPIO_OE_N_O[p] = 1'b1;
					end
					`PIN_CFG_PUSH_PULL:
					begin
						GPIO_O[p]      = ctl.latch[p];
						GPIO_OE_N_O[p] = 1'b0;
					end
					`PIN_CFG_OPEN_DRAIN:
					begin
						GPIO_OE_N_O[p] = ctl.latch[p];
					end
				endcase
			end

			quasi_drive_a : assert property (@(posedge CLK_I) disable iff (!RST_N_I)
				ctl.cfg[p] == `PIN_CFG_QUASI |-> (GPIO_WEAK_PU_O[p] == ctl.latch[p])
				&& (GPIO_OE_N_O[p] == ctl.latch[p]) && !GPIO_O[p])
				else $error("quasi pin drive wrong");
			input_off_a : assert property (@(posedge CLK_I) disable iff (!RST_N_I)
				ctl.cfg[p] == `PIN_CFG_INPUT |-> GPIO_OE_N_O[p] && !GPIO_WEAK_PU_O[p])
				else $error("input pin is driven");
			push_pull_a : assert property (@(posedge CLK_I) disable iff (!RST_N_I)
				ctl.cfg[p] == `PIN_CFG_PUSH_PULL |-> !GPIO_OE_N_O[p]
				&& (GPIO_O[p] == ctl.latch[p]))
				else $error("push-pull pin drive wrong");
			open_drain_a : assert property (@(posedge CLK_I) disable iff (!RST_N_I)
				ctl.cfg[p] == `PIN_CFG_OPEN_DRAIN |-> !GPIO_WEAK_PU_O[p] && !GPIO_O[p]
				&& (GPIO_OE_N_O[p] == ctl.latch[p]))
				else $error("open-drain pin drive wrong");
		end
	endgenerate

	level_filter_a : assert property (@(posedge CLK_I) disable iff (!RST_N_I)
		(sync_b != sync_c) |=> $stable(level))
		else $error("pin level took an unsettled input");

endmodule

`default_nettype wire

// ===== rtl/uart_i2c_bridge_config_regs.sv
/*
 * Configuration register bank of a serial-to-bus master bridge: baud
 * divisor and rate tick, pin configuration and levels, own address,
 * SCL phase timing, SCL stuck time-out and frame status.
 * Assumes the command parser presents one register access per strobe
 * and the bus engine reports steps and frame ends on the same clock.
 */
// Overview of operation
// - Serial bit rate comes from a programmable counter in the rate generator.
// - Rate equals clock divided by sixteen plus the sixteen-bit divisor.
// - Host writes low then high divisor; new rate applies on high write.
// - Each pin has a two-bit mode: quasi, input, push-pull, open-drain.
// - Pins 0-3 configured by low config register, 4-7 by high.
// - Quasi pin: weak high when latch is 1, strong low when 0.
// - Input-only pin never drives and acts only as sampled input.
// - Push-pull pin drives latch value strongly, high and low.
// - Open-drain pin has no pull-ups, pulls low only on latch 0.
// - Reading pin level returns the actual state of all eight pins.
// - Writing pin level updates each output pin's latch.
// - After reset every pin is an input; level reflects external pins.
// - Own address sits in bits 7:1, MSB first; bit 0 written zero.
// - SCL frequency is clock over twice the high plus low counts.
// - SCL high and low phases timed independently from their registers.
// - With time-out enabled, SCL held low too long resets the engine.
// - Time-out counter reloads on every engine state transition.
// - Time-out register: bit 0 enable, bits 7:1 time-out value.
// - Time-out period is value times 256 over 57600 seconds.
// - Status reads upper nibble ones, lower nibble the frame result.
// - Register writes arrive as address and data pairs, applied at once.
// - Register reads return each addressed register's contents.
`include "bridge_regs_defines.svh"
`timescale 1ns/100ps
`default_nettype none

module uart_i2c_bridge_config_regs
#(
	parameter int TO_UNIT_CYCLES = `TO_UNIT_CYCLES,
	parameter int TO_PRE_W       = 18,
	parameter int BAUD_CNT_W     = 17
)
(
	input  wire logic        CLK_I,
	input  wire logic        RST_N_I,
	input  wire logic        REG_WR_I,
	input  wire logic        REG_RD_I,
	input  wire logic  [7:0] REG_ADDR_I,
	input  wire logic  [7:0] REG_WDATA_I,
	output logic       [7:0] REG_RDATA_O,
	output logic             REG_RVALID_O,
	output logic             BAUD_TICK_O,
	output logic      [15:0] BAUD_DIVISOR_O,
	output logic       [6:0] OWN_ADDR_O,
	input  wire logic        BUS_ACTIVE_I,
	input  wire logic        FSM_STEP_I,
	input  wire logic        SCL_I,
	output logic             SCL_LOW_O,
	output logic             BUS_RESET_O,
	input  wire logic        FRAME_DONE_I,
	input  wire logic  [3:0] FRAME_RESULT_I,
	input  wire logic  [7:0] GPIO_I,
	output logic       [7:0] GPIO_O,
	output logic       [7:0] GPIO_OE_N_O,
	output logic       [7:0] GPIO_WEAK_PU_O
);

	function automatic logic hit(input logic [7:0] addr, input logic [7:0] offset);
		hit = (addr == offset);
	endfunction

	// ------------------------------------------------------------------
	// Register storage
	// ------------------------------------------------------------------
	logic [7:0] baud_low;
	logic [7:0] baud_high;
	logic [7:0] pin_cfg_low;
	logic [7:0] pin_cfg_high;
	logic [7:0] pin_latch;
	logic [7:0] own_addr;
	logic [7:0] scl_low_cnt;
	logic [7:0] scl_high_cnt;
	logic [7:0] scl_timeout;
	logic [3:0] frame_code;
	logic       timeout_hit;

	pin_ctrl_if pins ();

	always_ff @(posedge CLK_I or negedge RST_N_I)
	begin
		if (!RST_N_I)
		begin
			baud_low     <= `RST_BAUD_LOW;
			baud_high    <= `RST_BAUD_HIGH;
			own_addr     <= `RST_OWN_ADDR;
			scl_low_cnt  <= `RST_SCL_LOW;
			scl_high_cnt <= `RST_SCL_HIGH;
			scl_timeout  <= `RST_SCL_TIMEOUT;
		end
		else if (REG_WR_I)
		begin
			if (hit(REG_ADDR_I, `REG_BAUD_LOW))
				baud_low <= REG_WDATA_I;
			if (hit(REG_ADDR_I, `REG_BAUD_HIGH))
				baud_high <= REG_WDATA_I;
			if (hit(REG_ADDR_I, `REG_OWN_ADDR))
				own_addr <= REG_WDATA_I;
			if (hit(REG_ADDR_I, `REG_SCL_LOW))
				scl_low_cnt <= REG_WDATA_I;
			if (hit(REG_ADDR_I, `REG_SCL_HIGH))
				scl_high_cnt <= REG_WDATA_I;
			if (hit(REG_ADDR_I, `REG_SCL_TIMEOUT))
				scl_timeout <= REG_WDATA_I;
		end
	end

	// all pins come up as inputs
	always_ff @(posedge CLK_I or negedge RST_N_I)
	begin
		if (!RST_N_I)
		begin
			pin_cfg_low  <= `RST_PIN_CFG;
			pin_cfg_high <= `RST_PIN_CFG;
			pin_latch    <= `RST_PIN_LATCH;
		end
		else if (REG_WR_I)
		begin
			if (hit(REG_ADDR_I, `REG_PIN_CFG_LOW))
				pin_cfg_low <= REG_WDATA_I;
			if (hit(REG_ADDR_I, `REG_PIN_CFG_HIGH))
				pin_cfg_high <= REG_WDATA_I;
			if (hit(REG_ADDR_I, `REG_PIN_LEVEL))
				pin_latch <= REG_WDATA_I;
		end
	end

	assign OWN_ADDR_O = own_addr[`OWN_ADDR_MSB:`OWN_ADDR_LSB];

	// ------------------------------------------------------------------
	// Pin bank
	// ------------------------------------------------------------------
	genvar g;
	generate
		for (g = 0; g < 4; g++)
		begin : g_cfg
			assign pins.cfg[g]     = pin_cfg_low[2*g+1:2*g];
			assign pins.cfg[g + 4] = pin_cfg_high[2*g+1:2*g];
		end
	endgenerate

	assign pins.latch = pin_latch;

	pin_bank u_pin_bank
	(
		.CLK_I          (CLK_I),
		.RST_N_I        (RST_N_I),
		.ctl            (pins.bank),
		.GPIO_I         (GPIO_I),
		.GPIO_O         (GPIO_O),
		.GPIO_OE_N_O    (GPIO_OE_N_O),
		.GPIO_WEAK_PU_O (GPIO_WEAK_PU_O)
	);

	// ------------------------------------------------------------------
	// Read port
	// ------------------------------------------------------------------
	// registered read data
	always_ff @(posedge CLK_I or negedge RST_N_I)
	begin
		if (!RST_N_I)
		begin
			REG_RDATA_O  <= 8'h00;
			REG_RVALID_O <= 1'b0;
		end
		else
		begin
			REG_RVALID_O <= REG_RD_I;
			if (REG_RD_I)
			begin
				unique case (REG_ADDR_I)
					`REG_BAUD_LOW:     REG_RDATA_O <= baud_low;
					`REG_BAUD_HIGH:    REG_RDATA_O <= baud_high;
					`REG_PIN_CFG_LOW:  REG_RDATA_O <= pin_cfg_low;
					`REG_PIN_CFG_HIGH: REG_RDATA_O <= pin_cfg_high;
					`REG_PIN_LEVEL:    REG_RDATA_O <= pins.level;
					`REG_OWN_ADDR:     REG_RDATA_O <= own_addr;
					`REG_SCL_LOW:      REG_RDATA_O <= scl_low_cnt;
					`REG_SCL_HIGH:     REG_RDATA_O <= scl_high_cnt;
					`REG_SCL_TIMEOUT:  REG_RDATA_O <= scl_timeout;
					`REG_FRAME_STATUS: REG_RDATA_O <= {`STAT_UPPER, frame_code};
					default:           REG_RDATA_O <= `RST_RESERVED;
				endcase
			end
		end
	end

	// ------------------------------------------------------------------
	// Baud rate generator
	// ------------------------------------------------------------------
	logic [BAUD_CNT_W-1:0] baud_cnt;
	logic [BAUD_CNT_W-1:0] baud_last;

	always_ff @(posedge CLK_I or negedge RST_N_I)
	begin
		if (!RST_N_I)
			BAUD_DIVISOR_O <= {`RST_BAUD_HIGH, `RST_BAUD_LOW};
		else if (REG_WR_I && hit(REG_ADDR_I, `REG_BAUD_HIGH))
			BAUD_DIVISOR_O <= {REG_WDATA_I, baud_low};
	end

	assign baud_last = BAUD_CNT_W'(`BAUD_BASE + {1'b0, BAUD_DIVISOR_O} - 17'h00001);

	always_ff @(posedge CLK_I or negedge RST_N_I)
	begin
		if (!RST_N_I)
		begin
			baud_cnt    <= '0;
			BAUD_TICK_O <= 1'b0;
		end
		else if (baud_cnt >= baud_last)
		begin
			baud_cnt    <= '0;
			BAUD_TICK_O <= 1'b1;
		end
		else
		begin
			baud_cnt    <= baud_cnt + 1'b1;
			BAUD_TICK_O <= 1'b0;
		end
	end

	// ------------------------------------------------------------------
	// SCL phase timing
	// ------------------------------------------------------------------
	bridge_regs_pkg::scl_phase_e phase;
	logic [8:0] phase_cnt;
	logic [8:0] phase_len;

	always_comb
	begin
		unique case (phase)
			bridge_regs_pkg::PH_HIGH: phase_len = {scl_high_cnt, 1'b0};
			bridge_regs_pkg::PH_LOW:  phase_len = {scl_low_cnt, 1'b0};
			bridge_regs_pkg::PH_IDLE: phase_len = 9'h000;
			default:                  phase_len = 9'h000;
		endcase
	end

	always_ff @(posedge CLK_I or negedge RST_N_I)
	begin
		if (!RST_N_I)
		begin
			phase     <= bridge_regs_pkg::PH_IDLE;
			phase_cnt <= 9'h000;
		end
		else if (!BUS_ACTIVE_I)
		begin
			phase     <= bridge_regs_pkg::PH_IDLE;
			phase_cnt <= 9'h000;
		end
		else
		begin
			unique case (phase)
				bridge_regs_pkg::PH_IDLE:
				begin
					phase     <= bridge_regs_pkg::PH_LOW;
					phase_cnt <= 9'h000;
				end
				bridge_regs_pkg::PH_HIGH,
				bridge_regs_pkg::PH_LOW:
				begin
					if (phase_cnt + 9'h001 >= phase_len)
					begin
						phase     <= (phase == bridge_regs_pkg::PH_LOW) ?
							bridge_regs_pkg::PH_HIGH : bridge_regs_pkg::PH_LOW;
						phase_cnt <= 9'h000;
					end
					else
						phase_cnt <= phase_cnt + 9'h001;
				end
			endcase
		end
	end

	assign SCL_LOW_O = (phase == bridge_regs_pkg::PH_LOW);

	// ------------------------------------------------------------------
	// SCL stuck time-out
	// ------------------------------------------------------------------
	logic                scl_a;
	logic                scl_b;
	logic                scl_c;
	logic                scl_level;
	logic [TO_PRE_W-1:0] to_pre;
	logic [6:0]          to_left;
	logic                to_enable;
	logic [6:0]          to_value;

	assign to_enable = scl_timeout[`TO_ENABLE_BIT];
	assign to_value  = scl_timeout[`TO_VALUE_MSB:`TO_VALUE_LSB];

	always_ff @(posedge CLK_I or negedge RST_N_I)
	begin
		if (!RST_N_I)
		begin
			scl_a     <= 1'b1;
			scl_b     <= 1'b1;
			scl_c     <= 1'b1;
			scl_level <= 1'b1;
		end
		else
		begin
			scl_a <= SCL_I;
			scl_b <= scl_a;
			scl_c <= scl_b;
			if (scl_b == scl_c)
				scl_level <= scl_c;
		end
	end

	always_ff @(posedge CLK_I or negedge RST_N_I)
	begin
		if (!RST_N_I)
		begin
			to_pre      <= '0;
			to_left     <= 7'h00;
			timeout_hit <= 1'b0;
		end
		else if (!BUS_ACTIVE_I || FSM_STEP_I || scl_level || !to_enable)
		begin
			to_pre      <= '0;
			to_left     <= to_value;
			timeout_hit <= 1'b0;
		end
		else if (to_pre == TO_PRE_W'(TO_UNIT_CYCLES - 1))
		begin
			to_pre      <= '0;
			timeout_hit <= (to_left <= 7'h01);
			to_left     <= (to_left <= 7'h01) ? to_value : to_left - 7'h01;
		end
		else
		begin
			to_pre      <= to_pre + 1'b1;
			timeout_hit <= 1'b0;
		end
	end

	assign BUS_RESET_O = timeout_hit;

	// ------------------------------------------------------------------
	// Frame status
	// ------------------------------------------------------------------
	// updated at each frame end and on a time-out, time-out first
	always_ff @(posedge CLK_I or negedge RST_N_I)
	begin
		if (!RST_N_I)
			frame_code <= `STAT_OK;
		else if (timeout_hit)
			frame_code <= `STAT_TIMEOUT;
		else if (FRAME_DONE_I)
			frame_code <= FRAME_RESULT_I;
	end

	// ------------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------------
	baud_apply_a : assert property (@(posedge CLK_I) disable iff (!RST_N_I)
		REG_WR_I && REG_ADDR_I == `REG_BAUD_HIGH
		|=> BAUD_DIVISOR_O == {$past(REG_WDATA_I), baud_low})
		else $error("divisor not applied on high write");
	baud_hold_a : assert property (@(posedge CLK_I) disable iff (!RST_N_I)
		!(REG_WR_I && REG_ADDR_I == `REG_BAUD_HIGH) |=> $stable(BAUD_DIVISOR_O))
		else $error("divisor changed without high write");
	baud_period_a : assert property (@(posedge CLK_I) disable iff (!RST_N_I)
		BAUD_TICK_O && $stable(BAUD_DIVISOR_O) |=> !BAUD_TICK_O)
		else $error("rate tick period shorter than divisor");
	read_valid_a : assert property (@(posedge CLK_I) disable iff (!RST_N_I)
		REG_RD_I |=> REG_RVALID_O)
		else $error("read not answered next cycle");
	status_upper_a : assert property (@(posedge CLK_I) disable iff (!RST_N_I)
		REG_RD_I && REG_ADDR_I == `REG_FRAME_STATUS |=> REG_RDATA_O[7:4] == `STAT_UPPER)
		else $error("status upper nibble not ones");
	status_hold_a : assert property (@(posedge CLK_I) disable iff (!RST_N_I)
		!FRAME_DONE_I && !timeout_hit |=> $stable(frame_code))
		else $error("status changed without frame end");
	timeout_code_a : assert property (@(posedge CLK_I) disable iff (!RST_N_I)
		timeout_hit |=> frame_code == `STAT_TIMEOUT)
		else $error("time-out not reported");
	timeout_reload_a : assert property (@(posedge CLK_I) disable iff (!RST_N_I)
		FSM_STEP_I |=> to_left == $past(to_value) && to_pre == '0 && !timeout_hit)
		else $error("time-out not reloaded on step");
	timeout_off_a : assert property (@(posedge CLK_I) disable iff (!RST_N_I)
		!to_enable |=> !BUS_RESET_O)
		else $error("time-out fired while disabled");
	scl_high_len_a : assert property (@(posedge CLK_I) disable iff (!RST_N_I)
		BUS_ACTIVE_I && $rose(phase == bridge_regs_pkg::PH_HIGH) && scl_high_cnt != 8'h00
		|=> phase == bridge_regs_pkg::PH_HIGH)
		else $error("SCL high phase too short");

endmodule

`default_nettype wire

// ===== verif/host_model.sv
/* Host side model: one register write or read per call.
   Assumes the bench calls its tasks and the bank answers in one cycle. */
`timescale 1ns/100ps
`default_nettype none

module host_model
(
	input  wire logic       clk_i,
	output logic            wr_o,
	output logic            rd_o,
	output logic      [7:0] addr_o,
	output logic      [7:0] wdata_o,
	input  wire logic [7:0] rdata_i,
	input  wire logic       rvalid_i
);
	initial
	begin
		wr_o = 1'b0;
		rd_o = 1'b0;
		addr_o = 8'h00;
		wdata_o = 8'h00;
	end

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge clk_i);
		addr_o = a;
		wdata_o = d;
		wr_o = 1'b1;
		@(negedge clk_i);
		wr_o = 1'b0;
		addr_o = ~a;
		wdata_o = ~d;
	endtask

	task automatic rd(input logic [7:0] a, output logic [8:0] r);
		@(negedge clk_i);
		addr_o = a;
		rd_o = 1'b1;
		@(negedge clk_i);
		rd_o = 1'b0;
		addr_o = ~a;
		r = {rvalid_i, rdata_i};
	endtask
endmodule

`default_nettype wire

// ===== verif/uart_i2c_bridge_config_regs_bench.sv
/* Self-checking bench of the configuration register bank.
   Assumes a 50 MHz clock and a shortened time-out unit of 4 clocks. */
`timescale 1ns/100ps
`default_nettype none

module uart_i2c_bridge_config_regs_bench;
	logic clk = 1'b0, rst_n = 1'b0, wr, rd, tick, scl_low, bus_rst, rvalid;
	logic act = 1'b0, step = 1'b0, scl = 1'b1, done = 1'b0;
	logic [3:0] res = 4'h0;
	logic [7:0] addr, wdata, rdata, gpio_o, oe_n, pu, pad, ext = 8'ha5;
	logic [15:0] div;
	logic [6:0] own;
	logic [8:0] r;
	int mismatches = 0, checks = 0, n, k;

	always #10 clk = ~clk;
	// Pad: driven, weak pull-up, else external pattern
	assign pad = (~oe_n & gpio_o) | (oe_n & pu) | (oe_n & ~pu & ext);

	host_model u_host (.clk_i(clk), .wr_o(wr), .rd_o(rd), .addr_o(addr),
		.wdata_o(wdata), .rdata_i(rdata), .rvalid_i(rvalid));

	uart_i2c_bridge_config_regs #(.TO_UNIT_CYCLES(4)) u_dut (.CLK_I(clk),
		.RST_N_I(rst_n), .REG_WR_I(wr), .REG_RD_I(rd), .REG_ADDR_I(addr),
		.REG_WDATA_I(wdata), .REG_RDATA_O(rdata), .REG_RVALID_O(rvalid),
		.BAUD_TICK_O(tick), .BAUD_DIVISOR_O(div), .OWN_ADDR_O(own),
		.BUS_ACTIVE_I(act), .FSM_STEP_I(step), .SCL_I(scl),
		.SCL_LOW_O(scl_low), .BUS_RESET_O(bus_rst), .FRAME_DONE_I(done),
		.FRAME_RESULT_I(res), .GPIO_I(pad), .GPIO_O(gpio_o),
		.GPIO_OE_N_O(oe_n), .GPIO_WEAK_PU_O(pu));

	// ----
	// Checking and closing
	// ----
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		checks++;
		if (seen !== exp)
		begin
			mismatches++;
			$display("CHECK FAILED %0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic report_and_stop;
		$display("checks %0d mismatches %0d", checks, mismatches);
		if (mismatches == 0 && checks > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	task automatic hang;
		mismatches++;
		report_and_stop();
	endtask

	// Cycles that a signal keeps value v
	task automatic run(input logic v, input bit use_tick, output int c);
		c = 0;
		do
		begin
			@(negedge clk);
			c++;
		end
		while (((use_tick ? tick : scl_low) === v) && c < 400);
		if (c >= 400)
			hang();
	endtask

	// ----
	// Scenarios
	// ----
	task automatic t_reset;
		logic [7:0] e [0:11] = '{8'hf0, 8'h02, 8'h55, 8'h55, 8'ha5, 8'h00,
			8'h26, 8'h13, 8'h13, 8'h66, 8'hf0, 8'h00};
		for (int i = 0; i < 12; i++)
		begin
			u_host.rd(i[7:0], r);
			check(r, {1'b1, e[i]});
		end
		check(div, 16'h02f0);
		check(oe_n, 8'hff);
		$display("test reset done");
	endtask

	task automatic t_baud;
		u_host.wr(8'h00, 8'h05);
		check(div, 16'h02f0);
		u_host.wr(8'h01, 8'h00);
		check(div, 16'h0005);
		run(1'b0, 1'b1, n);
		run(1'b1, 1'b1, n);
		run(1'b0, 1'b1, n);
		check(n + 1, 21);
		$display("test baud done");
	endtask

	task automatic t_pins;
		u_host.wr(8'h02, 8'he4);
		u_host.wr(8'h03, 8'he4);
		u_host.wr(8'h04, 8'h00);
		check({oe_n, gpio_o}, 16'h2200);
		u_host.wr(8'h04, 8'hff);
		check({oe_n, gpio_o}, 16'hbb44);
		check(pu, 8'h11);
		repeat (6) @(negedge clk);
		u_host.rd(8'h04, r);
		check(r, 9'h1f5);
		$display("test pins done");
	endtask

	task automatic t_scl;
		u_host.wr(8'h06, 8'h5a);
		check(own, 7'h2d);
		// sum of counts kept at ten
		u_host.wr(8'h07, 8'h06);
		u_host.wr(8'h08, 8'h04);
		act = 1'b1;
		run(1'b0, 1'b0, n);
		run(1'b1, 1'b0, n);
		run(1'b0, 1'b0, n);
		check(n, 8);
		run(1'b1, 1'b0, n);
		check(n, 12);
		act = 1'b0;
		$display("test scl done");
	endtask

	task automatic t_timeout;
		@(negedge clk);
		scl = 1'b0;
		act = 1'b1;
		k = 0;
		// Steps closer than the twelve-cycle limit
		for (int i = 0; i < 73; i++)
		begin
			@(negedge clk);
			if (i == 2)
				u_host.wr(8'h09, 8'h07);
			step = (i % 8 == 0);
			k += (bus_rst === 1'b1);
		end
		check(k, 0);
		n = 0;
		do
		begin
			@(negedge clk);
			step = 1'b0;
			n++;
		end
		while (bus_rst !== 1'b1 && n < 40);
		check(n >= 12 && n <= 18, 1);
		u_host.rd(8'h0a, r);
		check(r, 9'h1f8);
		act = 1'b0;
		scl = 1'b1;
		$display("test timeout done");
	endtask

	task automatic t_status;
		logic [3:0] c [0:2] = '{4'h1, 4'h2, 4'h0};
		for (int i = 0; i < 3; i++)
		begin
			@(negedge clk);
			res = c[i];
			done = 1'b1;
			@(negedge clk);
			done = 1'b0;
			res = 4'h2;
			u_host.rd(8'h0a, r);
			check(r, {5'h1f, c[i]});
		end
		u_host.wr(8'h0a, 8'h01);
		u_host.wr(8'h05, 8'hff);
		u_host.rd(8'h05, r);
		check(r, 9'h100);
		u_host.rd(8'h0a, r);
		check(r, 9'h1f0);
		$display("test status done");
	endtask

	initial
	begin
		repeat (12) @(posedge clk);
		@(negedge clk);
		rst_n = 1'b1;
		t_reset();
		t_baud();
		t_pins();
		t_scl();
		t_timeout();
		t_status();
		report_and_stop();
	end
endmodule

`default_nettype wire
